//--- design/dctpg_pkg.sv
// Package with constants for the data channel test pattern generator.
package dctpg_pkg;

   // Structure defaults.
   localparam int NUM_CH = 4;
   localparam int WORD_W = 10;

   // Register byte offsets; seed registers follow one word per channel.
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] SEED_OFS = 12'h010;
   localparam logic [11:0] SEED_STRIDE = 12'h004;

   // Control register bit positions and reset value.
   localparam int CTRL_SYNTH_BIT = 0;
   localparam int CTRL_COUNT_BIT = 1;
   localparam int CTRL_PRBS_BIT = 2;
   localparam int CTRL_FRAMED_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h8;

   // Status register bit positions.
   localparam int STAT_OVR_BIT = 0;
   localparam int STAT_WIN_BIT = 1;
   localparam int STAT_TEST_BIT = 2;

   // Seed reset value, nonzero so the random generator never sticks.
   localparam logic [WORD_W-1:0] SEED_RST = 10'h001;

   // Line coding words and polynomials.
   localparam logic [WORD_W-1:0] TRAIN_WORD = 10'h3a6;
   localparam logic [WORD_W-1:0] CRC_POLY = 10'h233;
   localparam logic [WORD_W-1:0] LFSR_TAPS = 10'h240;

   // Synchroniser depth for every input from the word clock domain.
   localparam int SYNC_STAGES = 2;

endpackage

//--- design/dctpg_top.sv
// Data channel test pattern generator with APB registers and an output buffer.
`timescale 1ns/1ps
`default_nettype none

module dctpg_top #(
   parameter int NUM_CH = dctpg_pkg::NUM_CH,
   parameter int WORD_W = dctpg_pkg::WORD_W
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // APB slave.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Word clock domain inputs from the readout path.
   input wire logic word_clk_i,
   input wire logic window_i,
   input wire logic line_start_i,
   input wire logic crc_slot_i,
   input wire logic [NUM_CH*WORD_W-1:0] pix_data_i,
   input wire logic [WORD_W-1:0] sync_code_i,
   // Output word stream toward the serialisers.
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [NUM_CH*WORD_W-1:0] out_data_o,
   output logic [WORD_W-1:0] out_sync_o
);

   localparam int LINK_W = 4 + NUM_CH * WORD_W + WORD_W;
   localparam int BUF_W = NUM_CH * WORD_W + WORD_W;

   // CRC of one word folded into a running value, one bit per step.
   function automatic logic [WORD_W-1:0] crc_next(input logic [WORD_W-1:0] c,
                                                  input logic [WORD_W-1:0] w);
      logic [WORD_W-1:0] r;
      logic fb;
      r = c;
      for (int b = WORD_W - 1; b >= 0; b--) begin
         fb = r[WORD_W-1] ^ w[b];
         r = {r[WORD_W-2:0], 1'b0};
         if (fb) begin
            r = r ^ dctpg_pkg::CRC_POLY;
         end
      end
      return r;
   endfunction

   // Galois shift register step; an all-zero state stays zero.
   function automatic logic [WORD_W-1:0] lfsr_next(input logic [WORD_W-1:0] s);
      logic [WORD_W-1:0] r;
      r = {1'b0, s[WORD_W-1:1]};
      if (s[0]) begin
         r = r ^ dctpg_pkg::LFSR_TAPS;
      end
      return r;
   endfunction

   // Crossing from the word clock domain.
   // Every link bit, the word clock included, passes the same two stages,
   // so a word and its clock edge reach the logic in the same cycle.
   logic [LINK_W-1:0] link_raw;
   logic [LINK_W-1:0] sync1_q;
   logic [LINK_W-1:0] sync2_q;
   logic wclk_prev_q;
   logic word_stb;
   logic win_s;
   logic lstart_s;
   logic crcslot_s;
   logic [NUM_CH*WORD_W-1:0] pix_s;
   logic [WORD_W-1:0] sync_s;

   assign link_raw = {word_clk_i, window_i, line_start_i, crc_slot_i, pix_data_i, sync_code_i};

   // Two flip-flops per bit; the data is stable around the word clock rising edge,
   // and the slow word clock leaves several cycles for it to settle.
   genvar gs;
   generate
      for (gs = 0; gs < LINK_W; gs++) begin : g_sync
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               sync1_q[gs] <= 1'b0;
               sync2_q[gs] <= 1'b0;
            end else begin
               sync1_q[gs] <= link_raw[gs];
               sync2_q[gs] <= sync1_q[gs];
            end
         end
      end
   endgenerate

   // Edge detector on the synchronised word clock.
   // It resets low, the idle level of the word clock, so no false word follows reset.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wclk_prev_q <= 1'b0;
      end else begin
         wclk_prev_q <= sync2_q[LINK_W-1];
      end
   end

   assign word_stb = sync2_q[LINK_W-1] & ~wclk_prev_q;
   assign win_s = sync2_q[LINK_W-2];
   assign lstart_s = sync2_q[LINK_W-3];
   assign crcslot_s = sync2_q[LINK_W-4];
   assign pix_s = sync2_q[NUM_CH*WORD_W+WORD_W-1:WORD_W];
   assign sync_s = sync2_q[WORD_W-1:0];

   // Register file over APB.
   // Seeds and mode bits live here; the generators reload from them while idle.
   // Writes land only on mapped addresses, so a stray write changes nothing.
   logic [3:0] ctrl_q;
   logic [WORD_W-1:0] seed_q [NUM_CH];
   logic ovr_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic hit_d;
   logic hit_q;
   logic wr_en;
   logic synth_en;
   logic count_sel;
   logic prbs_sel;
   logic framed;
   logic test_on;
   logic push;
   logic push_ok;
   logic buf_in_ready;

   assign synth_en = ctrl_q[dctpg_pkg::CTRL_SYNTH_BIT];
   assign count_sel = ctrl_q[dctpg_pkg::CTRL_COUNT_BIT];
   assign prbs_sel = ctrl_q[dctpg_pkg::CTRL_PRBS_BIT];
   assign framed = ctrl_q[dctpg_pkg::CTRL_FRAMED_BIT];
   assign test_on = prbs_sel | synth_en;
   assign wr_en = psel_i & penable_i & pwrite_i & hit_q;

   // Address decode and read mux, evaluated in the setup phase.
   always_comb begin
      rdata_d = 32'h0000_0000;
      hit_d = 1'b0;
      if (paddr_i == dctpg_pkg::CTRL_OFS) begin
         hit_d = 1'b1;
         rdata_d[3:0] = ctrl_q;
      end else if (paddr_i == dctpg_pkg::STAT_OFS) begin
         hit_d = 1'b1;
         rdata_d[dctpg_pkg::STAT_OVR_BIT] = ovr_q;
         rdata_d[dctpg_pkg::STAT_WIN_BIT] = win_s;
         rdata_d[dctpg_pkg::STAT_TEST_BIT] = test_on;
      end
      for (int i = 0; i < NUM_CH; i++) begin
         if (paddr_i == 12'(dctpg_pkg::SEED_OFS + 12'(i) * dctpg_pkg::SEED_STRIDE)) begin
            hit_d = 1'b1;
            rdata_d[WORD_W-1:0] = seed_q[i];
         end
      end
   end

   // Read data and decode result are caught in the setup phase and held
   // through the access phase, so the answer comes from flip-flops.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q <= 32'h0000_0000;
         hit_q <= 1'b0;
      end else if (psel_i & ~penable_i) begin
         rdata_q <= pwrite_i ? 32'h0000_0000 : rdata_d;
         hit_q <= hit_d;
      end
   end

   // No wait states: decode settled in the setup phase, so each access ends at once.
   assign pready_o = psel_i & penable_i;
   // An unmapped address answers with an error, ignores writes and reads as zero.
   assign pslverr_o = psel_i & penable_i & ~hit_q;
   assign prdata_o = rdata_q;

   // Control register.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_q <= dctpg_pkg::CTRL_RST;
      end else if (wr_en && paddr_i == dctpg_pkg::CTRL_OFS) begin
         ctrl_q <= pwdata_i[3:0];
      end
   end

   // Per-channel seed words, one register each.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            seed_q[i] <= dctpg_pkg::SEED_RST;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (wr_en &&
                paddr_i == 12'(dctpg_pkg::SEED_OFS + 12'(i) * dctpg_pkg::SEED_STRIDE)) begin
               seed_q[i] <= pwdata_i[WORD_W-1:0];
            end
         end
      end
   end

   // Sticky overrun flag, write one to clear; a new overrun wins over the clear.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovr_q <= 1'b0;
      end else if (word_stb & ~buf_in_ready) begin
         ovr_q <= 1'b1;
      end else if (wr_en && paddr_i == dctpg_pkg::STAT_OFS &&
                   pwdata_i[dctpg_pkg::STAT_OVR_BIT]) begin
         ovr_q <= 1'b0;
      end
   end

   // Per-channel word generation.
   // Each channel has its own counter, random generator and running CRC,
   // so no channel ever depends on another's state.
   // A word is taken from the link only when the buffer can hold it; a word
   // arriving while the buffer is full is dropped and flagged, and the
   // generators stall so the pattern sequence stays unbroken for the receiver.
   assign push = word_stb;
   assign push_ok = push & buf_in_ready;

   logic [NUM_CH*WORD_W-1:0] gen_data;

   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
         logic [WORD_W-1:0] inc_q;
         logic [WORD_W-1:0] lfsr_q;
         logic [WORD_W-1:0] crc_q;
         logic [WORD_W-1:0] inc_word;
         logic [WORD_W-1:0] pix_word;
         logic [WORD_W-1:0] gen_word;
         logic [WORD_W-1:0] out_word;
         logic inc_mode;
         logic in_data;
         logic gen_used;

         assign pix_word = pix_s[gc*WORD_W +: WORD_W];
         assign inc_mode = synth_en & count_sel & ~prbs_sel;
         // Line start reloads the counter when the stream is framed.
         assign inc_word = (framed & lstart_s) ? seed_q[gc] : inc_q;

         // Source word selection; the random generator wins over all else.
         always_comb begin
            if (prbs_sel) begin
               gen_word = lfsr_q;
            end else if (!synth_en) begin
               gen_word = pix_word;
            end else if (count_sel) begin
               gen_word = inc_word;
            end else begin
               gen_word = seed_q[gc];
            end
         end

         // Framing of the line: training words outside the window, CRC in its slot, or a random word there while the random generator is selected.
         // Unframed test output carries no training or CRC words, only pattern words.
         assign in_data = (!test_on || framed) ? (win_s & ~crcslot_s) : 1'b1;
         always_comb begin
            if (test_on && !framed) begin
               out_word = gen_word;
            end else if (crcslot_s) begin
               out_word = prbs_sel ? lfsr_q : crc_q;
            end else if (win_s) begin
               out_word = gen_word;
            end else begin
               out_word = dctpg_pkg::TRAIN_WORD;
            end
         end

         assign gen_used = in_data | (prbs_sel & crcslot_s);
         assign gen_data[gc*WORD_W +: WORD_W] = out_word;

         // Incrementing counter, as wide as the pixel word.
         // Dropped words do not advance it, so the receiver sees an unbroken count.
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               inc_q <= dctpg_pkg::SEED_RST;
            end else if (!inc_mode) begin
               inc_q <= seed_q[gc];
            end else if (push_ok && gen_used) begin
               if (inc_word == {WORD_W{1'b1}}) begin
                  inc_q <= seed_q[gc];
               end else begin
                  inc_q <= inc_word + 1'b1;
               end
            end
         end

         // Pseudo-random generator, reloaded from this channel's seed while idle.
         // A zero seed locks it at zero; software is expected to avoid that.
         // It also advances on the CRC slot, which carries one more random word.
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               lfsr_q <= dctpg_pkg::SEED_RST;
            end else if (!prbs_sel) begin
               lfsr_q <= seed_q[gc];
            end else if (push_ok && gen_used) begin
               lfsr_q <= lfsr_next(lfsr_q);
            end
         end

         // Running CRC over the data words of a line, cleared after its slot.
         // Restarting at each line start keeps one bad line from spoiling the next.
         always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               crc_q <= '0;
            end else if (push_ok) begin
               if (crcslot_s) begin
                  crc_q <= '0;
               end else if (win_s) begin
                  crc_q <= crc_next(lstart_s ? '0 : crc_q, out_word);
               end
            end
         end
      end
   endgenerate

   // Two-entry output buffer.
   // Two entries let one word wait while the next arrives, so a short
   // receiver stall costs nothing; a longer one is flagged as overrun.
   logic [BUF_W-1:0] buf_mem [2];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] cnt_q;
   logic pop;

   assign buf_in_ready = (cnt_q != 2'd2);
   assign out_valid_o = (cnt_q != 2'd0);
   assign pop = out_valid_o & out_ready_i;

   // Storage; the sync code rides beside the data unchanged.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
      end else if (push_ok) begin
         buf_mem[wr_ptr_q] <= {gen_data, sync_s};
      end
   end

   // Pointers and fill count.
   // A push and a pop in one cycle leave the fill count unchanged.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'd0;
      end else begin
         if (push_ok) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (push_ok && !pop) begin
            cnt_q <= cnt_q + 2'd1;
         end else if (pop && !push_ok) begin
            cnt_q <= cnt_q - 2'd1;
         end
      end
   end

   assign out_data_o = buf_mem[rd_ptr_q][BUF_W-1:WORD_W];
   assign out_sync_o = buf_mem[rd_ptr_q][WORD_W-1:0];

endmodule

`default_nettype wire

//--- test/dctpg_props.sv
// Property checker for the register and stream ports of the pattern generator.
`timescale 1ns/1ps
`default_nettype none
module dctpg_props #(
   parameter int NUM_CH = 4,
   parameter int WORD_W = 10
) (
   // Clock, reset and register bus.
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Link clock and output stream.
   input wire logic word_clk_i,
   input wire logic out_valid_o,
   input wire logic out_ready_i,
   input wire logic [NUM_CH*WORD_W-1:0] out_data_o,
   input wire logic [WORD_W-1:0] out_sync_o
);
   logic acc, pop, map, have_q;
   logic [3:0] ctrl_q;
   logic [NUM_CH*WORD_W-1:0] seed_q;
   logic [WORD_W-1:0] last_q;
   // Access phase, stream pop and address decode.
   assign acc = psel_i && penable_i;
   assign pop = out_valid_o && out_ready_i;
   assign map = paddr_i == 12'h000 || paddr_i == 12'h004 || (paddr_i[1:0] == 2'h0
      && paddr_i >= 12'h010 && paddr_i < 12'h010 + 12'(4 * NUM_CH));
   // Shadow of mode and seeds, so the stream checks know the expected words.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_q <= dctpg_pkg::CTRL_RST;
         seed_q <= {NUM_CH{dctpg_pkg::SEED_RST}};
      end else if (acc && pwrite_i) begin
         if (paddr_i == 12'h000) ctrl_q <= pwdata_i[3:0];
         for (int i = 0; i < NUM_CH; i++) begin
            if (paddr_i == 12'h010 + 12'(4 * i)) seed_q[i*WORD_W +: WORD_W] <= pwdata_i[WORD_W-1:0];
         end
      end
   end
   // Last popped count word; forgotten whenever the free count mode is left.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         last_q <= '0;
         have_q <= 1'b0;
      end else if (ctrl_q != 4'h3) begin
         have_q <= 1'b0;
      end else if (pop) begin
         last_q <= out_data_o[WORD_W-1:0];
         have_q <= 1'b1;
      end
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   chk_ready_access: assert property (acc |-> pready_o)
      else $error("pready low in access");
   chk_ready_idle: assert property (!acc |-> !pready_o)
      else $error("pready outside access");
   chk_err_decode: assert property (acc |-> pslverr_o == !map)
      else $error("pslverr wrong");
   chk_read_ctrl: assert property (acc && !pwrite_i && paddr_i == 12'h0 |->
      prdata_o == {28'h0, ctrl_q})
      else $error("control readback wrong");
   chk_word_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o
      && $stable(out_data_o) && $stable(out_sync_o))
      else $error("stalled word changed");
   chk_take_bound: assert property ($rose(word_clk_i) && !out_valid_o |-> ##[1:5] out_valid_o)
      else $error("word not taken");
   chk_fixed_word: assert property (ctrl_q == 4'h1 && out_valid_o |->
      out_data_o == seed_q)
      else $error("fixed word wrong");
   chk_count_step: assert property (have_q && pop |->
      out_data_o[WORD_W-1:0] == (last_q == '1 ? seed_q[WORD_W-1:0] : last_q + 1'b1))
      else $error("count step wrong");
   cover property (have_q && pop && last_q == '1);
   cover property (acc && pslverr_o);
   cover property (out_valid_o && !out_ready_i ##1 out_valid_o);
endmodule
bind dctpg_top dctpg_props #(.NUM_CH(NUM_CH), .WORD_W(WORD_W)) u_props (.ref_clk_i(ref_clk_i),
   .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .word_clk_i(word_clk_i), .out_valid_o(out_valid_o),
   .out_ready_i(out_ready_i), .out_data_o(out_data_o), .out_sync_o(out_sync_o));
`default_nettype wire

//--- test/dctpg_rx.sv
// Model of the image data receiver that takes the output word stream.
`timescale 1ns/1ps
`default_nettype none
module dctpg_rx #(
   parameter int DW = 50
) (
   // Clock, reset and stall control.
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic stall_i,
   // Word stream from the generator.
   input wire logic valid_i,
   input wire logic [DW-1:0] word_i,
   output logic ready_o
);
   logic [1:0] k_q;
   logic [DW-1:0] got[$];
   // Ready drops one cycle in four, and wholly while stalled, to work the buffer.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         k_q <= 2'h0;
         ready_o <= 1'b0;
      end else begin
         k_q <= k_q + 2'h1;
         ready_o <= !stall_i && k_q != 2'h3;
      end
   end
   // Words are kept whole as they come, with no demultiplexing per channel.
   always @(posedge clk_i) begin
      if (valid_i && ready_o) got.push_back(word_i);
   end
endmodule
`default_nettype wire

//--- test/dctpg_bench.sv
// Self-checking testbench for the data channel test pattern generator.
`timescale 1ns/1ps
`default_nettype none
module dctpg_bench;
   localparam int NC = dctpg_pkg::NUM_CH;
   localparam int W = dctpg_pkg::WORD_W;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, stall = 1'b0;
   logic wclk = 1'b0, win = 1'b0, ls = 1'b0, cs = 1'b0, prdy, perr, ov, ordy, er;
   logic [11:0] pad = 12'h0;
   logic [31:0] pwd = 32'h0, prd, r;
   logic [NC*W-1:0] pix = '0, od;
   logic [W-1:0] sc = '0, os;
   logic [15:0] lf = 16'h000b;
   logic [3:0] ctl = 4'h8;
   logic [NC*W+W-1:0] eq[$];
   logic [3:0] md[8] = '{4'h8, 4'h0, 4'h9, 4'hb, 4'h3, 4'h1, 4'hc, 4'h7};
   int bs[8] = '{-1, -1, -1, 'h3fc, 'h3fc, -1, -1, -1};
   int ln[8] = '{3, 2, 3, 5, 4, 1, 3, 3};
   int n_mismatch = 0, compares = 0, cyc = 0;
   int sd[NC], cnt[NC], prs[NC], crc[NC];
   dctpg_top DUT (.ref_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
      .pslverr_o(perr), .word_clk_i(wclk), .window_i(win), .line_start_i(ls),
      .crc_slot_i(cs), .pix_data_i(pix), .sync_code_i(sc), .out_valid_o(ov),
      .out_ready_i(ordy), .out_data_o(od), .out_sync_o(os));
   dctpg_rx #(.DW(NC*W+W)) rx (.clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .valid_i(ov),
      .word_i({os, od}), .ready_o(ordy));
   // Clock at 10 MHz.
   initial begin
      forever #50 clk = ~clk;
   end
   function automatic logic [W-1:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[W-1:0];
   endfunction
   function automatic int crcw(int c, int d);
      for (int i = W - 1; i >= 0; i--) begin
         c = ((c << 1) & ((1 << W) - 1)) ^
             ((((c >> (W - 1)) ^ (d >> i)) & 1) ? dctpg_pkg::CRC_POLY : 0);
      end
      return c;
   endfunction
   task automatic chk(input string nm, input logic [NC*W+W-1:0] s, input logic [NC*W+W-1:0] x);
      compares++;
      if (s !== x) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pad <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      r = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // The model works out each word before the link clock carries it in.
   // One word lasts eight clock cycles, 800 ns; the inputs change as the word clock falls.
   task automatic word(input logic w, input logic l, input logic c, input logic keep);
      logic [NC*W-1:0] p, x;
      logic [W-1:0] s;
      logic fr;
      int v;
      for (int i = 0; i < NC; i++) p[i*W +: W] = rnd();
      s = rnd();
      fr = ctl[3] || !(ctl[2] || ctl[0]);
      for (int i = 0; i < NC && keep; i++) begin
         if (fr && !w && !c) v = dctpg_pkg::TRAIN_WORD;
         else if (fr && c && !ctl[2]) v = crc[i];
         else if (ctl[2]) begin
            v = prs[i];
            prs[i] = prs[i] & 1 ? (prs[i] >> 1) ^ dctpg_pkg::LFSR_TAPS : prs[i] >> 1;
         end else if (!ctl[0]) v = p[i*W +: W];
         else if (!ctl[1]) v = sd[i];
         else begin
            if (fr && l) cnt[i] = sd[i];
            v = cnt[i];
            cnt[i] = v == (1 << W) - 1 ? sd[i] : v + 1;
         end
         if (fr && w && !c) crc[i] = crcw(l ? 0 : crc[i], v);
         if (fr && c) crc[i] = 0;
         x[i*W +: W] = v[W-1:0];
      end
      if (keep) eq.push_back({s, x});
      win <= w;
      ls <= l;
      cs <= c;
      pix <= p;
      sc <= s;
      repeat (4) @(posedge clk);
      wclk <= 1'b1;
      repeat (4) @(posedge clk);
      wclk <= 1'b0;
   endtask
   task automatic line(input int n);
      word(1, 1, 0, 1);
      repeat (n) word(1, 0, 0, 1);
      word(0, 0, 1, 1);
      word(0, 0, 0, 1);
   endtask
   // Passing through the normal mode reloads every generator from its seed.
   task automatic cfg(input logic [3:0] c, input int b);
      ctl = 4'h0;
      apb(1, 12'h000, 32'h0);
      for (int i = 0; i < NC; i++) begin
         sd[i] = b < 0 ? int'(rnd() | 10'h001) : b + i;
         cnt[i] = sd[i];
         prs[i] = sd[i];
         apb(1, 12'h010 + 12'(4 * i), 32'(sd[i]));
      end
      apb(1, 12'h000, {28'h0, c});
      ctl = c;
   endtask
   task automatic fin(input string nm);
      for (int i = 0; i < 400 && rx.got.size() < eq.size(); i++) @(posedge clk);
      chk("word count", rx.got.size(), eq.size());
      while (eq.size() > 0 && rx.got.size() > 0) begin
         chk(nm, rx.got.pop_front(), eq.pop_front());
      end
      eq.delete();
      rx.got.delete();
      $display("test %s done", nm);
   endtask
   // Main sequence: reset values, every mode, then a stalled receiver.
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, 12'h000, 32'h0);
      chk("ctrl reset", r, 32'h8);
      apb(0, 12'h010, 32'h0);
      chk("seed reset", r, 32'h1);
      apb(1, 12'h008, 32'h3ff);
      chk("unmapped error", er, 1'b1);
      foreach (md[t]) begin
         cfg(md[t], bs[t]);
         line(ln[t]);
         line(2);
         fin($sformatf("mode %h", md[t]));
      end
      stall <= 1'b1;
      word(0, 0, 0, 1);
      word(0, 0, 0, 1);
      word(0, 0, 0, 0);
      apb(0, 12'h004, 32'h0);
      chk("status overrun", r, 32'h5);
      apb(1, 12'h004, 32'h1);
      apb(0, 12'h004, 32'h0);
      chk("status clear", r, 32'h4);
      stall <= 1'b0;
      fin("overrun");
      print_verdict();
   end
   // A hang is cut short well beyond the thousand or so cycles the run needs.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         print_verdict();
      end
   end
endmodule
`default_nettype wire
